// *** verilog/lagc_map.svh ***
// Register map, reset values, field positions and timing counts of the loudness leveler.
// Assumes a 40 MHz system clock and byte addresses on a 32-bit Avalon-MM slave.
`ifndef LAGC_MAP_SVH
`define LAGC_MAP_SVH
`define LAGC_A_CTRL 6'h00
`define LAGC_A_SIL 6'h04
`define LAGC_A_TGT 6'h08
`define LAGC_A_SPR 6'h0C
`define LAGC_A_TRN 6'h10
`define LAGC_A_MATT 6'h14
`define LAGC_A_MGAIN 6'h18
`define LAGC_A_LINK 6'h1C
`define LAGC_A_HSEL 6'h20
`define LAGC_A_HIDX 6'h24
`define LAGC_A_HDAT 6'h28
`define LAGC_A_STAT 6'h2C
`define LAGC_A_LVL 6'h30
`define LAGC_B_MASTER 0
`define LAGC_B_POST 1
`define LAGC_R_SIL 8'shD8
`define LAGC_R_TGT 8'shE8
`define LAGC_R_SPR 8'sh01
`define LAGC_R_TRN 8'sh06
`define LAGC_R_MATT 8'shF4
`define LAGC_R_MGAIN 8'sh0C
`define LAGC_SIL_MIN 8'shBA
`define LAGC_TGT_MIN 8'shCE
`define LAGC_SPR_MAX 8'sh32
`define LAGC_TRN_MIN 8'sh01
`define LAGC_TRN_MAX 8'sh3C
`define LAGC_GLIM 8'sh0C
`define LAGC_FLOOR_Q 11'sh670
`define LAGC_CLK_NS 25
`define LAGC_STEP_NS 15_625_000
`define LAGC_STEP_CYC (`LAGC_STEP_NS / `LAGC_CLK_NS)
`define LAGC_HIST_MS 1000
`define LAGC_HIST_CYC (`LAGC_HIST_MS * 1_000_000 / `LAGC_CLK_NS)
`define LAGC_HIST_SPAN_S 120
`define LAGC_HIST_DEPTH (`LAGC_HIST_SPAN_S * 1000 / `LAGC_HIST_MS)
`endif

// *** verilog/lagc_pkg.sv ***
// Types shared by the loudness leveler.
// Assumes lagc_map.svh supplies the numeric constants.
`default_nettype none
package lagc_pkg;
  typedef enum logic [0:0] {LAGC_ST_IDLE = 1'b0, LAGC_ST_SCAN = 1'b1} lagc_state_e;
  typedef logic signed [7:0] lagc_db_t;
  typedef logic signed [7:0] lagc_gain_t;
  typedef logic signed [10:0] lagc_qdb_t;
endpackage : lagc_pkg
`default_nettype wire

// *** verilog/lagc_leveler.sv ***
// Sixteen-channel loudness leveler with Avalon-MM control and a two-minute history.
// Assumes one 40 MHz clock, inputs synchronous to it, and a mixer that honours valid/ready.
// How it works
// - Each channel's level measured independently
// - Gain moves one step per tick toward band
// - Linked channels share their leader's gain
// - One gain multiplies the whole sample
// - Master off ramps gain back to unity
// - Master on derives gain from measured level
// - Applied gain readable in quarter decibels
// - Silence threshold 0 to -70, default -40
// - Target 0 to -50, default -24
// - Spread 0 to 50, default 1
// - Transition time 0.5 to 30 s
// - Attenuation limited, 0 to -12 dB
// - Gain limited, 0 to +12 dB
// - Two-minute history of one selected channel
// - Running average; output level adds gain
// - Leveling runs whatever the history shows
//
// Register access over Avalon-MM and the register offsets were decided locally.
`include "lagc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lagc_leveler #(
  parameter int DW = 24,
  parameter int STEP_CYC = `LAGC_STEP_CYC,
  parameter int HIST_CYC = `LAGC_HIST_CYC,
  parameter int HDEPTH = `LAGC_HIST_DEPTH,
  parameter int FAST_SH = 6,
  parameter int SLOW_SH = 13
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [3:0] s_chan,
  input wire logic [DW-1:0] s_data,
  output logic m_valid,
  input wire logic m_ready,
  output logic [3:0] m_chan,
  output logic [DW-1:0] m_data,
  input wire lagc_pkg::lagc_db_t mix_trim_db
);
  import lagc_pkg::*;
  localparam int NCH = 16;
  localparam int HAW = $clog2(HDEPTH);
  localparam int SCW = $clog2(STEP_CYC);
  localparam int HCW = $clog2(HIST_CYC);

  function automatic lagc_db_t clamp_db(input lagc_db_t v, input lagc_db_t lo, input lagc_db_t hi);
    clamp_db = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_db

  // Log of an envelope in quarter dB, 0.75 dB resolution; empty envelope reads as floor
  function automatic lagc_qdb_t lvl_q(input logic [DW-1:0] e);
    int pos;
    logic [DW-1:0] sh;
    pos = 0;
    for (int i = 0; i < DW; i++) begin
      if (e[i]) begin
        pos = i;
      end
    end
    sh = e << (DW - 1 - pos);
    if (e == '0) begin
      lvl_q = `LAGC_FLOOR_Q;
    end else begin
      lvl_q = lagc_qdb_t'(((pos - (DW - 1)) * 8 + int'(sh[DW-2 -: 3])) * 3);
    end
  endfunction : lvl_q

  // One gain step is 1/16 octave, about 0.375 dB
  function automatic lagc_qdb_t gain_q(input lagc_gain_t g);
    lagc_qdb_t x;
    x = lagc_qdb_t'(g);
    gain_q = x + (x >>> 1);
  endfunction : gain_q

  function automatic logic [15:0] mant(input logic [3:0] f);
    case (f)
      4'h0: mant = 16'h4000;
      4'h1: mant = 16'h42D5;
      4'h2: mant = 16'h45CB;
      4'h3: mant = 16'h48E2;
      4'h4: mant = 16'h4C1C;
      4'h5: mant = 16'h4F7B;
      4'h6: mant = 16'h52FF;
      4'h7: mant = 16'h56AC;
      4'h8: mant = 16'h5A82;
      4'h9: mant = 16'h5E84;
      4'hA: mant = 16'h62B4;
      4'hB: mant = 16'h6712;
      4'hC: mant = 16'h6BA2;
      4'hD: mant = 16'h7066;
      4'hE: mant = 16'h7560;
      default: mant = 16'h7A92;
    endcase
  endfunction : mant

  // Bus slave: one wait cycle on every access
  logic done_ff, nxt_done;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_en;
  // Configuration
  logic master_ff, nxt_master, post_ff, nxt_post;
  lagc_db_t sil_ff, nxt_sil, tgt_ff, nxt_tgt, spr_ff, nxt_spr, trn_ff, nxt_trn;
  lagc_db_t matt_ff, nxt_matt, mgain_ff, nxt_mgain;
  logic [15:0] link_ff, nxt_link;
  logic [3:0] hsel_ff, nxt_hsel;
  logic [HAW-1:0] hidx_ff, nxt_hidx;
  // Per-channel state
  logic [DW-1:0] fe_ff [NCH], nxt_fe [NCH], se_ff [NCH], nxt_se [NCH];
  lagc_gain_t gain_ff [NCH], nxt_gain [NCH];
  lagc_state_e st_ff, nxt_st;
  logic [3:0] svc_ff, nxt_svc;
  logic [SCW-1:0] stc_ff, nxt_stc;
  logic [5:0] unc_ff, nxt_unc;
  // History
  logic [31:0] hist_ff [HDEPTH], nxt_hist [HDEPTH];
  logic [HAW-1:0] hwp_ff, nxt_hwp;
  logic [HAW:0] hcnt_ff, nxt_hcnt;
  logic [HCW-1:0] htc_ff, nxt_htc;
  // Output buffer
  logic [DW+3:0] fq_ff [2], nxt_fq [2];
  logic fwp_ff, nxt_fwp, frp_ff, nxt_frp;
  logic [1:0] fcnt_ff, nxt_fcnt;

  logic push, pop, tick;
  lagc_gain_t cur_g, lim_g, lim_a;
  lagc_qdb_t in_q, avg_q, sel_gq, fin_q;
  logic [31:0] hentry;
  logic [HAW-1:0] hrd;

  assign avs_waitrequest = (avs_read | avs_write) & ~done_ff;
  assign wr_en = avs_write & done_ff;
  assign avs_readdata = rdata_ff;
  assign lim_g = lagc_gain_t'((mgain_ff * 8'sh08) / 8'sh03);
  assign lim_a = lagc_gain_t'((-matt_ff * 8'sh08) / 8'sh03);
  assign cur_g = gain_ff[svc_ff];

  // Status of the history channel; the selector only feeds monitoring
  always_comb begin
    in_q = lvl_q(fe_ff[hsel_ff]);
    avg_q = lvl_q(se_ff[hsel_ff]);
    sel_gq = gain_q(gain_ff[hsel_ff]);
    fin_q = avg_q + sel_gq + (post_ff ? (lagc_qdb_t'(mix_trim_db) <<< 2) : '0);
    hentry = {8'(in_q >>> 2), 8'(avg_q >>> 2), 8'(sel_gq >>> 2), 8'(fin_q >>> 2)};
    if (hwp_ff > hidx_ff) begin
      hrd = HAW'(hwp_ff - hidx_ff - 1'b1);
    end else begin
      hrd = HAW'(HDEPTH + int'(hwp_ff) - int'(hidx_ff) - 1);
    end
  end

  always_comb begin
    nxt_done = (avs_read | avs_write) & ~done_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !done_ff) begin
      case (avs_address)
        `LAGC_A_CTRL: nxt_rdata = 32'({post_ff, master_ff});
        `LAGC_A_SIL: nxt_rdata = 32'(sil_ff);
        `LAGC_A_TGT: nxt_rdata = 32'(tgt_ff);
        `LAGC_A_SPR: nxt_rdata = 32'(spr_ff);
        `LAGC_A_TRN: nxt_rdata = 32'(trn_ff);
        `LAGC_A_MATT: nxt_rdata = 32'(matt_ff);
        `LAGC_A_MGAIN: nxt_rdata = 32'(mgain_ff);
        `LAGC_A_LINK: nxt_rdata = 32'(link_ff);
        `LAGC_A_HSEL: nxt_rdata = 32'(hsel_ff) + 32'h0000_0001;
        `LAGC_A_HIDX: nxt_rdata = {16'(hcnt_ff), 16'(hidx_ff)};
        `LAGC_A_HDAT: nxt_rdata = ({1'b0, hidx_ff} < hcnt_ff) ? hist_ff[hrd] : 32'h0000_0000;
        `LAGC_A_STAT: nxt_rdata = {16'(fin_q), 16'(sel_gq)};
        `LAGC_A_LVL: nxt_rdata = {16'(avg_q), 16'(in_q)};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  // Written values are clamped into their legal ranges rather than refused
  always_comb begin
    nxt_master = master_ff;
    nxt_post = post_ff;
    nxt_sil = sil_ff;
    nxt_tgt = tgt_ff;
    nxt_spr = spr_ff;
    nxt_trn = trn_ff;
    nxt_matt = matt_ff;
    nxt_mgain = mgain_ff;
    nxt_link = link_ff;
    nxt_hsel = hsel_ff;
    nxt_hidx = hidx_ff;
    if (wr_en && avs_byteenable[0]) begin
      case (avs_address)
        `LAGC_A_CTRL: begin
          nxt_master = avs_writedata[`LAGC_B_MASTER];
          nxt_post = avs_writedata[`LAGC_B_POST];
        end
        `LAGC_A_SIL: nxt_sil = clamp_db(avs_writedata[7:0], `LAGC_SIL_MIN, 8'sh00);
        `LAGC_A_TGT: nxt_tgt = clamp_db(avs_writedata[7:0], `LAGC_TGT_MIN, 8'sh00);
        `LAGC_A_SPR: nxt_spr = clamp_db(avs_writedata[7:0], 8'sh00, `LAGC_SPR_MAX);
        `LAGC_A_TRN: nxt_trn = clamp_db(avs_writedata[7:0], `LAGC_TRN_MIN, `LAGC_TRN_MAX);
        `LAGC_A_MATT: nxt_matt = clamp_db(avs_writedata[7:0], -`LAGC_GLIM, 8'sh00);
        `LAGC_A_MGAIN: nxt_mgain = clamp_db(avs_writedata[7:0], 8'sh00, `LAGC_GLIM);
        `LAGC_A_HSEL: nxt_hsel = 4'(clamp_db(avs_writedata[7:0], 8'sh01, 8'sh10) - 8'sh01);
        `LAGC_A_HIDX: nxt_hidx = HAW'(clamp_db(avs_writedata[7:0], 8'sh00, 8'(HDEPTH - 1)));
        `LAGC_A_LINK: nxt_link[7:1] = avs_writedata[7:1];
        default: nxt_link = link_ff;
      endcase
    end
    if (wr_en && avs_byteenable[1] && avs_address == `LAGC_A_LINK) begin
      nxt_link[15:8] = avs_writedata[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      master_ff <= 1'b0;
      post_ff <= 1'b0;
      sil_ff <= `LAGC_R_SIL;
      tgt_ff <= `LAGC_R_TGT;
      spr_ff <= `LAGC_R_SPR;
      trn_ff <= `LAGC_R_TRN;
      matt_ff <= `LAGC_R_MATT;
      mgain_ff <= `LAGC_R_MGAIN;
      link_ff <= 16'h0000;
      hsel_ff <= 4'h0;
      hidx_ff <= '0;
    end else begin
      master_ff <= nxt_master;
      post_ff <= nxt_post;
      sil_ff <= nxt_sil;
      tgt_ff <= nxt_tgt;
      spr_ff <= nxt_spr;
      trn_ff <= nxt_trn;
      matt_ff <= nxt_matt;
      mgain_ff <= nxt_mgain;
      link_ff <= nxt_link;
      hsel_ff <= nxt_hsel;
      hidx_ff <= nxt_hidx;
    end
  end

  // Sample path: gain applied as a plain multiply, so the program's dynamics are kept
  logic signed [DW+16:0] prod;
  logic signed [DW+19:0] scaled;
  logic signed [3:0] oct;
  logic [DW-1:0] outs, mag;
  always_comb begin
    oct = gain_ff[s_chan][7:4];
    prod = $signed(s_data) * $signed({1'b0, mant(gain_ff[s_chan][3:0])});
    scaled = (DW + 20)'(prod >>> 14);
    scaled = (oct >= 0) ? (scaled <<< oct) : (scaled >>> (-oct));
    // Limits are signed so that negative samples are not mistaken for overflow
    if (scaled > $signed((DW + 20)'({1'b0, {(DW - 1){1'b1}}}))) begin
      outs = {1'b0, {(DW - 1){1'b1}}};
    end else if (scaled < -$signed((DW + 20)'({1'b0, {(DW - 1){1'b1}}}))) begin
      outs = {1'b1, {(DW - 1){1'b0}}};
    end else begin
      outs = scaled[DW-1:0];
    end
    mag = s_data[DW-1] ? DW'(-s_data) : s_data;
  end

  assign s_ready = (fcnt_ff != 2'd2);
  assign push = s_valid & s_ready;
  assign m_valid = (fcnt_ff != 2'd0);
  assign pop = m_valid & m_ready;
  assign m_chan = fq_ff[frp_ff][DW+3:DW];
  assign m_data = fq_ff[frp_ff][DW-1:0];

  always_comb begin
    nxt_fq = fq_ff;
    nxt_fwp = fwp_ff ^ push;
    nxt_frp = frp_ff ^ pop;
    nxt_fcnt = fcnt_ff + {1'b0, push} - {1'b0, pop};
    if (push) begin
      nxt_fq[fwp_ff] = {s_chan, outs};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fq_ff[0] <= '0;
      fq_ff[1] <= '0;
      fwp_ff <= 1'b0;
      frp_ff <= 1'b0;
      fcnt_ff <= 2'd0;
    end else begin
      fq_ff <= nxt_fq;
      fwp_ff <= nxt_fwp;
      frp_ff <= nxt_frp;
      fcnt_ff <= nxt_fcnt;
    end
  end

  // Fast envelope for the input level, slow one as the running average
  always_comb begin
    logic signed [DW:0] df, ds;
    df = '0;
    ds = '0;
    nxt_fe = fe_ff;
    nxt_se = se_ff;
    if (push) begin
      df = $signed({1'b0, mag}) - $signed({1'b0, fe_ff[s_chan]});
      ds = $signed({1'b0, mag}) - $signed({1'b0, se_ff[s_chan]});
      nxt_fe[s_chan] = DW'($signed({1'b0, fe_ff[s_chan]}) + (df >>> FAST_SH));
      nxt_se[s_chan] = DW'($signed({1'b0, se_ff[s_chan]}) + (ds >>> SLOW_SH));
    end
  end

  // Gain walk: each tick services all sixteen channels in order, leader before follower
  always_comb begin
    logic run;
    logic [DW-1:0] gmax;
    lagc_qdb_t glvl, outq;
    run = 1'b0;
    gmax = '0;
    glvl = '0;
    outq = '0;
    for (int j = 0; j < NCH; j++) begin
      if (j == int'(svc_ff)) begin
        run = 1'b1;
      end else if (j > int'(svc_ff) && !link_ff[j]) begin
        run = 1'b0;
      end
      if (run && se_ff[j] > gmax) begin
        gmax = se_ff[j];
      end
    end
    glvl = lvl_q(gmax);
    outq = glvl + gain_q(cur_g);
    nxt_gain = gain_ff;
    nxt_st = st_ff;
    nxt_svc = svc_ff;
    nxt_stc = (stc_ff == SCW'(STEP_CYC - 1)) ? '0 : stc_ff + 1'b1;
    nxt_unc = unc_ff;
    tick = 1'b0;
    if (stc_ff == SCW'(STEP_CYC - 1)) begin
      if (unc_ff >= 6'(trn_ff - 8'sh01)) begin
        nxt_unc = 6'h00;
        tick = 1'b1;
      end else begin
        nxt_unc = unc_ff + 6'h01;
      end
    end
    unique case (st_ff)
      LAGC_ST_IDLE: begin
        nxt_svc = 4'h0;
        if (tick) begin
          nxt_st = LAGC_ST_SCAN;
        end
      end
      LAGC_ST_SCAN: begin
        nxt_svc = svc_ff + 4'h1;
        if (svc_ff == 4'hF) begin
          nxt_st = LAGC_ST_IDLE;
        end
        if (link_ff[svc_ff] && svc_ff != 4'h0) begin
          nxt_gain[svc_ff] = gain_ff[svc_ff - 4'h1];
        end else if (!master_ff) begin
          if (cur_g > 0) begin
            nxt_gain[svc_ff] = cur_g - 8'sh01;
          end else if (cur_g < 0) begin
            nxt_gain[svc_ff] = cur_g + 8'sh01;
          end
        end else if (cur_g > lim_g) begin
          nxt_gain[svc_ff] = cur_g - 8'sh01;
        end else if (cur_g < -lim_a) begin
          nxt_gain[svc_ff] = cur_g + 8'sh01;
        end else if (glvl <= (lagc_qdb_t'(sil_ff) <<< 2)) begin
          nxt_gain[svc_ff] = cur_g;
        end else if (outq > (lagc_qdb_t'(tgt_ff + spr_ff) <<< 2) && cur_g > -lim_a) begin
          nxt_gain[svc_ff] = cur_g - 8'sh01;
        end else if (outq < (lagc_qdb_t'(tgt_ff - spr_ff) <<< 2) && cur_g < lim_g) begin
          nxt_gain[svc_ff] = cur_g + 8'sh01;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        fe_ff[c] <= '0;
        se_ff[c] <= '0;
        gain_ff[c] <= 8'sh00;
      end
      st_ff <= LAGC_ST_IDLE;
      svc_ff <= 4'h0;
      stc_ff <= '0;
      unc_ff <= 6'h00;
    end else begin
      fe_ff <= nxt_fe;
      se_ff <= nxt_se;
      gain_ff <= nxt_gain;
      st_ff <= nxt_st;
      svc_ff <= nxt_svc;
      stc_ff <= nxt_stc;
      unc_ff <= nxt_unc;
    end
  end

  // History ring: one entry per period, oldest overwritten
  always_comb begin
    nxt_hist = hist_ff;
    nxt_hwp = hwp_ff;
    nxt_hcnt = hcnt_ff;
    nxt_htc = htc_ff + 1'b1;
    if (htc_ff == HCW'(HIST_CYC - 1)) begin
      nxt_htc = '0;
      nxt_hist[hwp_ff] = hentry;
      nxt_hwp = (hwp_ff == HAW'(HDEPTH - 1)) ? '0 : hwp_ff + 1'b1;
      if (hcnt_ff != (HAW + 1)'(HDEPTH)) begin
        nxt_hcnt = hcnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int k = 0; k < HDEPTH; k++) begin
        hist_ff[k] <= 32'h0000_0000;
      end
      hwp_ff <= '0;
      hcnt_ff <= '0;
      htc_ff <= '0;
    end else begin
      hist_ff <= nxt_hist;
      hwp_ff <= nxt_hwp;
      hcnt_ff <= nxt_hcnt;
      htc_ff <= nxt_htc;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_WAIT_FIRST: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  AST_RAMP_OFF: assert property (st_ff == LAGC_ST_SCAN && !master_ff && !link_ff[svc_ff] && cur_g > 0
    |=> gain_ff[$past(svc_ff)] == $past(cur_g) - 8'sh01) else $error("gain not ramped toward unity");
  AST_SIL_HOLD: assert property (st_ff == LAGC_ST_SCAN && master_ff && svc_ff == 4'h0 && !link_ff[1]
    && lvl_q(se_ff[0]) <= (lagc_qdb_t'(sil_ff) <<< 2) && cur_g <= lim_g && cur_g >= -lim_a
    |=> $stable(gain_ff[0])) else $error("gain moved in silence");
  AST_GAIN_LIM: assert property (st_ff == LAGC_ST_SCAN && master_ff && !link_ff[svc_ff] && cur_g <= lim_g
    |=> gain_ff[$past(svc_ff)] <= $past(lim_g)) else $error("gain above limit");
  AST_ATT_LIM: assert property (st_ff == LAGC_ST_SCAN && master_ff && !link_ff[svc_ff] && cur_g >= -lim_a
    |=> gain_ff[$past(svc_ff)] >= -$past(lim_a)) else $error("attenuation beyond limit");
  AST_FOLLOW: assert property (st_ff == LAGC_ST_SCAN && link_ff[svc_ff] && svc_ff != 4'h0
    |=> gain_ff[$past(svc_ff)] == gain_ff[$past(svc_ff) - 4'h1]) else $error("linked gain differs");
  AST_SCAN_LEN: assert property ($rose(st_ff == LAGC_ST_SCAN) |-> (st_ff == LAGC_ST_SCAN) [*8]
    ##9 st_ff == LAGC_ST_IDLE) else $error("scan not sixteen cycles");
  AST_OUT_HOLD: assert property (m_valid && !m_ready |=> m_valid && $stable(m_data) && $stable(m_chan))
    else $error("output word lost under stall");
  AST_SEL_SAFE: assert property (wr_en && avs_address == `LAGC_A_HSEL
    && !(st_ff == LAGC_ST_SCAN && svc_ff == 4'h0)
    |=> $stable(gain_ff[0])) else $error("selector write moved gain");
endmodule : lagc_leveler
`default_nettype wire

// *** tb/lagc_mixer_model.sv ***
// Mixer channel path model: sample source into the leveler and sink for its corrected audio.
// Assumes the bench sets run, stall and amp on rising edges of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module lagc_mixer_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run,
  input wire logic stall,
  input wire logic [23:0] amp,
  output logic s_valid,
  input wire logic s_ready,
  output logic [3:0] s_chan,
  output logic [23:0] s_data,
  input wire logic m_valid,
  output logic m_ready,
  input wire logic [23:0] m_data,
  output int sent,
  output int got,
  output logic [23:0] last
);
  assign m_ready = !stall;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s_valid <= 1'b0;
      s_chan <= 4'h0;
      s_data <= 24'h00_0000;
      sent <= 0;
      got <= 0;
      last <= 24'h00_0000;
    end else begin
      if (s_valid && s_ready) begin
        sent <= sent + 1;
        s_chan <= s_chan + 4'h1;
      end
      // An offered sample stays put until taken; idle data toggles so a stale value never passes
      if (!s_valid || s_ready) begin
        s_valid <= run;
        s_data <= run ? amp : ~s_data;
      end
      if (m_valid && m_ready) begin
        got <= got + 1;
        last <= m_data;
      end
    end
  end
endmodule : lagc_mixer_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench of the loudness leveler: register access, buffering and gain behaviour.
// Assumes lagc_mixer_model on the sample side and short step and history counts.
`include "lagc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lagc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic s_valid, s_ready, m_valid, m_ready;
  logic [3:0] s_chan, m_chan;
  logic [23:0] s_data, m_data, last;
  logic run = 1'b0;
  logic stall = 1'b0;
  logic [23:0] amp = 24'h00_0000;
  lagc_db_t trim = 8'sh00;
  int sent, got;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [5:0] ra[9] = '{`LAGC_A_CTRL, `LAGC_A_SIL, `LAGC_A_TGT, `LAGC_A_SPR, `LAGC_A_TRN,
    `LAGC_A_MATT, `LAGC_A_MGAIN, `LAGC_A_LINK, `LAGC_A_HSEL};
  logic [31:0] re[9] = '{32'h0000_0000, 32'hFFFF_FFD8, 32'hFFFF_FFE8, 32'h0000_0001, 32'h0000_0006,
    32'hFFFF_FFF4, 32'h0000_000C, 32'h0000_0000, 32'h0000_0001};
  logic [5:0] ca[9] = '{`LAGC_A_SIL, `LAGC_A_TGT, `LAGC_A_SPR, `LAGC_A_TRN, `LAGC_A_TRN,
    `LAGC_A_MATT, `LAGC_A_MGAIN, `LAGC_A_HSEL, `LAGC_A_HSEL};
  logic [31:0] cw[9] = '{32'hFFFF_FF9C, 32'h0000_0005, 32'h0000_003C, 32'h0000_0000, 32'h0000_003D,
    32'hFFFF_FFEC, 32'h0000_0014, 32'h0000_0000, 32'h0000_0011};
  logic [31:0] ce[9] = '{32'hFFFF_FFBA, 32'h0000_0000, 32'h0000_0032, 32'h0000_0001, 32'h0000_003C,
    32'hFFFF_FFF4, 32'h0000_000C, 32'h0000_0001, 32'h0000_0010};
  // Narrow limits of 3 dB keep the walk to each limit at eight steps
  logic [5:0] ga[7] = '{`LAGC_A_SIL, `LAGC_A_TGT, `LAGC_A_SPR, `LAGC_A_TRN, `LAGC_A_MATT,
    `LAGC_A_MGAIN, `LAGC_A_HSEL};
  logic [31:0] gw[7] = '{32'hFFFF_FFD8, 32'hFFFF_FFE8, 32'h0000_0001, 32'h0000_0001, 32'hFFFF_FFFD,
    32'h0000_0003, 32'h0000_0001};

  always #12.5 clk_sys = ~clk_sys;

  lagc_leveler #(.STEP_CYC(32), .HIST_CYC(16), .FAST_SH(1), .SLOW_SH(2)) i_lagc_leveler (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .s_valid(s_valid),
    .s_ready(s_ready), .s_chan(s_chan), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
    .m_chan(m_chan), .m_data(m_data), .mix_trim_db(trim));

  lagc_mixer_model i_lagc_mixer_model (
    .clk_sys(clk_sys), .rst_b(rst_b), .run(run), .stall(stall), .amp(amp), .s_valid(s_valid),
    .s_ready(s_ready), .s_chan(s_chan), .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready),
    .m_data(m_data), .sent(sent), .got(got), .last(last));

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One Avalon access; waitrequest is looked at mid-cycle, so the edge that launches it never races
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    logic acc;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    acc = (avs_waitrequest === 1'b0);
    @(posedge clk_sys);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!acc) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : bus

  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : idle

  task automatic gain_is(input logic [15:0] q);
    bus(1'b0, `LAGC_A_STAT, 32'h0000_0000);
    chk({16'h0000, rd[15:0]}, {16'h0000, q});
  endtask : gain_is

  initial begin
    idle(2);
    rst_b <= 1'b1;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0000_0000);
      chk(rd, re[i]);
    end
    $display("test reset_values done");
    foreach (ca[i]) begin
      bus(1'b1, ca[i], cw[i]);
      bus(1'b0, ca[i], 32'h0000_0000);
      chk(rd, ce[i]);
    end
    bus(1'b1, 6'h38, 32'h0000_00FF);
    bus(1'b0, 6'h38, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    foreach (ga[i]) bus(1'b1, ga[i], gw[i]);
    $display("test clamping done");
    @(posedge clk_sys);
    stall <= 1'b1;
    amp <= 24'h00_1000;
    run <= 1'b1;
    idle(10);
    chk({31'h0, s_ready}, 32'h0000_0000);
    chk({31'h0, m_valid}, 32'h0000_0001);
    chk({8'h00, m_data}, 32'h0000_1000);
    chk({28'h0, m_chan}, 32'h0000_0000);
    rd = {8'h00, m_data};
    idle(3);
    chk({8'h00, m_data}, rd);
    run <= 1'b0;
    stall <= 1'b0;
    for (int n = 0; n < 50 && (m_valid !== 1'b0 || s_valid !== 1'b0); n++) idle(1);
    idle(2);
    chk(got, sent);
    chk({8'h00, last}, {8'h00, amp});
    $display("test buffer_and_unity done");
    bus(1'b1, `LAGC_A_CTRL, 32'h0000_0001);
    idle(300);
    gain_is(16'h0000);
    $display("test silence_hold done");
    @(posedge clk_sys);
    amp <= 24'h7F_FFFF;
    run <= 1'b1;
    idle(1500);
    gain_is(16'hFFF4);
    bus(1'b1, `LAGC_A_CTRL, 32'h0000_0000);
    bus(1'b0, `LAGC_A_STAT, 32'h0000_0000);
    chk({31'h0, rd[15:0] !== 16'h0000}, 32'h0000_0001);
    idle(600);
    gain_is(16'h0000);
    $display("test attenuate_and_release done");
    @(posedge clk_sys);
    amp <= 24'h04_0000;
    bus(1'b1, `LAGC_A_CTRL, 32'h0000_0001);
    idle(1500);
    gain_is(16'h000C);
    bus(1'b1, `LAGC_A_HSEL, 32'h0000_0002);
    gain_is(16'h000C);
    $display("test boost_and_select done");
    @(posedge clk_sys);
    trim <= 8'sh02;
    idle(20);
    bus(1'b0, `LAGC_A_LVL, 32'h0000_0000);
    chk(rd, 32'hFF88_FF88);
    bus(1'b0, `LAGC_A_STAT, 32'h0000_0000);
    chk(rd, 32'hFF94_000C);
    bus(1'b1, `LAGC_A_HIDX, 32'h0000_0000);
    bus(1'b0, `LAGC_A_HIDX, 32'h0000_0000);
    chk(rd, 32'h0078_0000);
    bus(1'b0, `LAGC_A_HDAT, 32'h0000_0000);
    chk(rd, 32'hE2E2_03E5);
    bus(1'b1, `LAGC_A_CTRL, 32'h0000_0003);
    bus(1'b0, `LAGC_A_STAT, 32'h0000_0000);
    chk(rd, 32'hFF9C_000C);
    bus(1'b1, `LAGC_A_LINK, 32'h0000_FFFF);
    bus(1'b0, `LAGC_A_LINK, 32'h0000_0000);
    chk(rd, 32'h0000_FFFE);
    idle(100);
    gain_is(16'h000C);
    $display("test history_trim_link done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
